// [src/pbt_bar_decode.sv]
// Inbound BAR decode and translation with interrupt and timeout options
`timescale 1ns/10ps
`default_nettype none
`include "pbt_defines.svh"
module pbt_bar_decode #(
   parameter int ADDR_W = 12,
   parameter int USR_N = 16,
   parameter int VT_WORDS = 64,
   parameter int VT_AW = 6,
   parameter int CTO_LONG_CYC = `PBT_CTO_LONG_MS * 1000 * `PBT_CLK_MHZ,
   parameter int CTO_SHORT_CYC = `PBT_CTO_SHORT_US * `PBT_CLK_MHZ
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output pbt_pkg::pbt_resp_t s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output pbt_pkg::pbt_resp_t s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic in_valid,
   input wire pbt_pkg::pbt_addr_t in_addr,
   input wire logic in_mem,
   input wire logic in_wr,
   input wire logic in_np,
   input wire logic [31:0] in_wdata,
   output logic out_valid,
   output pbt_pkg::pbt_addr_t out_addr,
   output logic [2:0] out_bar,
   output logic out_wr,
   output logic out_np,
   output logic [31:0] out_wdata,
   output logic ur_valid,
   output logic tbl_rvalid,
   output logic [31:0] tbl_rdata,
   input wire logic cpl_done,
   output logic cto_pulse,
   input wire logic [USR_N-1:0] usr_irq,
   output logic [3:0] intx,
   output logic msi_req,
   output logic [3:0] msi_vec,
   output logic msix_ext,
   output logic ext_cfg_en
);
   import pbt_pkg::*;

   logic [8:0] ctrl_ff;
   logic [8:0] baren_ff;
   logic [9:0] intr_ff;
   logic [5:0] sz_ff [6];
   logic [63:0] base_ff [6];
   logic [63:0] xl_ff [6];
   logic [5:0] eff;
   logic [5:0] w64;
   logic [5:0] szc [6];
   logic [63:0] mask [6];
   logic [5:0] hit;
   logic hit_any;
   logic [2:0] hit_idx;
   logic tbl_hit;
   logic aw_held_ff, w_held_ff;
   logic [ADDR_W-1:0] waddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic do_wr;
   logic [31:0] rd_data;
   logic rd_ok;
   logic cto_flag_ff, np_busy_ff;
   logic [`PBT_CTO_W-1:0] cto_cnt_ff;
   logic [`PBT_CTO_W-1:0] cto_lim;
   logic [USR_N-1:0] irq_prev_ff, irq_act, irq_rise;
   logic [4:0] mvecs;

   // Byte-lane merge for register writes
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
      end
      return r;
   endfunction

   // Legal window size for the BAR width
   function automatic logic [5:0] clamp_sz(input logic [5:0] sz, input logic wide);
      logic [5:0] hi;
      hi = wide ? `PBT_SZ_MAX64 : `PBT_SZ_MAX32;
      if (sz < `PBT_SZ_MIN) return `PBT_SZ_MIN;
      else if (sz > hi) return hi;
      else return sz;
   endfunction

   // Per-BAR decode of a register address: BAR index and sub-register
   function automatic logic bar_reg(input logic [ADDR_W-1:0] a, output logic [2:0] i,
                                    output logic [2:0] s);
      i = a[7:5];
      s = a[4:2];
      return a[11:8] == `PBT_BAR_PAGE && a[7:5] < 3'h6 && a[4:2] <= `PBT_BAR_XHI;
   endfunction

   // Effective enables, widths, windows and hits
   always_comb begin
      hit = 6'h0;
      for (int i = 0; i < 6; i++) begin
         if (i % 2 == 0) begin
            eff[i] = baren_ff[i];
            w64[i] = baren_ff[6 + i / 2] & baren_ff[i];
         end else begin
            eff[i] = baren_ff[i] & ~w64[i - 1];
            w64[i] = 1'b0;
         end
         if (ctrl_ff[`PBT_C_RP] && i >= 2) begin
            eff[i] = 1'b0;
            w64[i] = 1'b0;
         end
         szc[i] = clamp_sz(sz_ff[i], w64[i]);
         mask[i] = (64'h1 << szc[i]) - 64'h1;
         // Upper half of a 32-bit BAR is zero, so it never sees 64-bit addresses
         hit[i] = eff[i] && in_mem && ((in_addr & ~mask[i]) ==
                  ({w64[i] ? base_ff[i][63:32] : 32'h0, base_ff[i][31:0]} & ~mask[i]));
      end
   end

   // Lowest numbered BAR wins if windows overlap
   always_comb begin
      hit_idx = 3'h0;
      for (int i = 5; i >= 0; i--) begin
         if (hit[i]) hit_idx = 3'(i);
      end
   end
   assign hit_any = |hit;
   // On-chip table sits in the first 64 KB of the selected BAR
   assign tbl_hit = hit_any && ctrl_ff[`PBT_C_MSIX] && ctrl_ff[`PBT_C_VTON] &&
                    hit_idx == ctrl_ff[`PBT_C_VTBAR] &&
                    ((in_addr & mask[hit_idx]) >> `PBT_VT_LOG2) == 64'h0;

   // Forwarded request with the translated address
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_valid <= 1'b0;
         out_addr <= 64'h0;
         out_bar <= 3'h0;
         out_wr <= 1'b0;
         out_np <= 1'b0;
         out_wdata <= 32'h0;
      end else begin
         out_valid <= in_valid && hit_any && !tbl_hit;
         if (in_valid && hit_any && !tbl_hit) begin
            out_addr <= (xl_ff[hit_idx] & ~mask[hit_idx]) |
                        (in_addr & mask[hit_idx]);
            out_bar <= hit_idx;
            out_wr <= in_wr;
            out_np <= in_np;
            out_wdata <= in_wdata;
         end
      end
   end

   // Misses go to the link core's unsupported-request path
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ur_valid <= 1'b0;
         tbl_rvalid <= 1'b0;
      end else begin
         ur_valid <= in_valid && in_mem && !hit_any;
         tbl_rvalid <= in_valid && tbl_hit && !in_wr;
      end
   end

   // Table aliases above VT_WORDS words of the 64 KB region
   pbt_vt_mem #(.WORDS(VT_WORDS), .AW(VT_AW)) u_vt (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(in_valid && tbl_hit && in_wr),
      .addr(in_addr[VT_AW+1:2]),
      .wdata(in_wdata),
      .rdata(tbl_rdata)
   );

   // Write address and data may arrive in either order
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         waddr_ff <= '0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            s_axi_awready <= 1'b0;
            waddr_ff <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_held_ff <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end else if (do_wr) begin
            w_held_ff <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
      end
   end
   assign do_wr = aw_held_ff && w_held_ff && !s_axi_bvalid;

   // Write response; unmapped offsets answer SLVERR
   always_ff @(posedge clk or negedge rst_b) begin
      logic [2:0] bi, bs;
      if (!rst_b) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PBT_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (waddr_ff[11:2] < 10'h4 || bar_reg(waddr_ff, bi, bs)) ?
                        PBT_OKAY : PBT_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Global control registers; the merged word is cut to the register width
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= `PBT_CTRL_RST;
         baren_ff <= `PBT_BAREN_RST;
         intr_ff <= `PBT_INTR_RST;
      end else if (do_wr) begin
         case (waddr_ff[11:0])
            `PBT_REG_CTRL: ctrl_ff <= 9'(wmerge({23'h0, ctrl_ff}, wdata_ff, wstrb_ff));
            `PBT_REG_BAREN: baren_ff <= 9'(wmerge({23'h0, baren_ff}, wdata_ff, wstrb_ff));
            `PBT_REG_INTR: intr_ff <= 10'(wmerge({22'h0, intr_ff}, wdata_ff, wstrb_ff));
            default: ;
         endcase
      end
   end

   // Per-BAR size, link-side base and translation base
   always_ff @(posedge clk or negedge rst_b) begin
      logic [2:0] bi, bs;
      if (!rst_b) begin
         for (int i = 0; i < 6; i++) begin
            sz_ff[i] <= `PBT_SZ_RST;
            base_ff[i] <= 64'h0;
            xl_ff[i] <= 64'h0;
         end
      end else if (do_wr && bar_reg(waddr_ff, bi, bs)) begin
         unique case (bs)
            `PBT_BAR_SIZE: sz_ff[bi] <= 6'(wmerge({26'h0, sz_ff[bi]}, wdata_ff, wstrb_ff));
            `PBT_BAR_BLO: base_ff[bi][31:0] <= wmerge(base_ff[bi][31:0], wdata_ff, wstrb_ff);
            `PBT_BAR_BHI: base_ff[bi][63:32] <= wmerge(base_ff[bi][63:32], wdata_ff, wstrb_ff);
            `PBT_BAR_XLO: xl_ff[bi][31:0] <= wmerge(xl_ff[bi][31:0], wdata_ff, wstrb_ff);
            `PBT_BAR_XHI: xl_ff[bi][63:32] <= wmerge(xl_ff[bi][63:32], wdata_ff, wstrb_ff);
            default: ;
         endcase
      end
   end

   // Read mux; size registers also report type and prefetch
   always_comb begin
      logic [2:0] bi, bs;
      rd_data = 32'h0;
      rd_ok = 1'b1;
      bi = 3'h0;
      bs = 3'h0;
      if (bar_reg(s_axi_araddr, bi, bs)) begin
         unique case (bs)
            `PBT_BAR_SIZE: rd_data = {23'h0, w64[bi], w64[bi], eff[bi], szc[bi]};
            `PBT_BAR_BLO: rd_data = base_ff[bi][31:0];
            `PBT_BAR_BHI: rd_data = base_ff[bi][63:32];
            `PBT_BAR_XLO: rd_data = xl_ff[bi][31:0];
            `PBT_BAR_XHI: rd_data = xl_ff[bi][63:32];
            default: rd_ok = 1'b0;
         endcase
      end else begin
         case (s_axi_araddr[11:0])
            `PBT_REG_CTRL: rd_data = {23'h0, ctrl_ff};
            `PBT_REG_BAREN: rd_data = {23'h0, baren_ff};
            `PBT_REG_STATUS: rd_data = {17'h0, msix_ext, np_busy_ff, cto_flag_ff, w64, eff};
            `PBT_REG_INTR: rd_data = {22'h0, intr_ff};
            default: rd_ok = 1'b0;
         endcase
      end
   end

   // Read channel answers one cycle after the address is taken
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= PBT_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_ok ? PBT_OKAY : PBT_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Completion timeout on the newest outstanding non-posted request
   assign cto_lim = ctrl_ff[`PBT_C_CTOS] ? `PBT_CTO_W'(CTO_SHORT_CYC - 1) :
                    `PBT_CTO_W'(CTO_LONG_CYC - 1);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         np_busy_ff <= 1'b0;
         cto_cnt_ff <= '0;
         cto_pulse <= 1'b0;
      end else begin
         cto_pulse <= 1'b0;
         if (in_valid && hit_any && !tbl_hit && in_np) begin
            // A new request wins over a completion in the same cycle
            np_busy_ff <= 1'b1;
            cto_cnt_ff <= '0;
         end else if (cpl_done) begin
            np_busy_ff <= 1'b0;
         end else if (np_busy_ff && cto_cnt_ff == cto_lim) begin
            np_busy_ff <= 1'b0;
            cto_pulse <= 1'b1;
         end else if (np_busy_ff) begin
            cto_cnt_ff <= cto_cnt_ff + `PBT_CTO_W'(1);
         end
      end
   end

   // Sticky timeout flag; a new timeout beats a clear in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cto_flag_ff <= 1'b0;
      end else if (cto_pulse) begin
         cto_flag_ff <= 1'b1;
      end else if (do_wr && waddr_ff[11:0] == `PBT_REG_STATUS && wstrb_ff[1] &&
                   wdata_ff[`PBT_ST_CTO]) begin
         cto_flag_ff <= 1'b0;
      end
   end

   // Only the first count-plus-one user inputs take part
   always_comb begin
      for (int i = 0; i < USR_N; i++) begin
         irq_act[i] = usr_irq[i] && (5'(i) <= {1'b0, intr_ff[`PBT_I_UCNT]});
      end
   end
   assign irq_rise = irq_act & ~irq_prev_ff;
   assign mvecs = (intr_ff[`PBT_I_MVEC] > `PBT_MVEC_MAX) ? 5'h10 :
                  5'(5'h1 << intr_ff[`PBT_I_MVEC]);

   // Message interrupt on rising inputs, the lowest one winning in a cycle, folded onto the granted vectors
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_prev_ff <= '0;
         msi_req <= 1'b0;
         msi_vec <= 4'h0;
      end else begin
         irq_prev_ff <= irq_act;
         msi_req <= 1'b0;
         for (int i = USR_N - 1; i >= 0; i--) begin
            if (ctrl_ff[`PBT_C_MSI] && irq_rise[i]) begin
               msi_req <= 1'b1;
               msi_vec <= 4'(i) & 4'(mvecs - 5'h1);
            end
         end
      end
   end

   // Legacy level on one pin while message interrupts are off
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         intx <= 4'h0;
      end else begin
         intx <= (!ctrl_ff[`PBT_C_MSI] && |irq_act) ?
                 4'(4'h1 << intr_ff[`PBT_I_LEG]) : 4'h0;
      end
   end

   // Mode levels for outside logic
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         msix_ext <= 1'b0;
         ext_cfg_en <= 1'b0;
      end else begin
         msix_ext <= ctrl_ff[`PBT_C_MSIX] && !ctrl_ff[`PBT_C_VTON];
         ext_cfg_en <= ctrl_ff[`PBT_C_XCFG];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_miss_flagged: assert property (in_valid && in_mem && !hit_any
                                      |=> ur_valid && !out_valid)
      else $error("missed request not flagged");
   chk_odd_bar_off: assert property (baren_ff[6] && baren_ff[0]
                                     |-> !eff[1] && !hit[1])
      else $error("odd BAR live behind 64-bit BAR");
   chk_rp_two_bars: assert property (ctrl_ff[`PBT_C_RP] |-> eff[5:2] == 4'h0)
      else $error("root port decodes beyond BAR 1");
   chk_hit_forward: assert property (in_valid && hit_any && !tbl_hit
                                     |=> out_valid && out_bar == $past(hit_idx))
      else $error("hit not forwarded on its BAR");
   chk_xlat_base: assert property (in_valid && hit_any && !tbl_hit
                                   ##1 $stable(xl_ff[out_bar]) |->
                                   (out_addr & ~mask[out_bar]) ==
                                   (xl_ff[out_bar] & ~mask[out_bar]))
      else $error("translated base wrong");
   chk_size_range: assert property (szc[0] >= `PBT_SZ_MIN &&
                                    szc[0] <= `PBT_SZ_MAX64 &&
                                    (w64[0] || szc[0] <= `PBT_SZ_MAX32))
      else $error("window size out of range");
   chk_table_local: assert property (in_valid && tbl_hit && !in_wr
                                     |=> tbl_rvalid && !out_valid)
      else $error("table access leaked to bus");
   // The pin level lags the control register by one cycle, hence the past value
   chk_legacy_pin: assert property (intx != 4'h0 |-> $onehot(intx) &&
                                    !$past(ctrl_ff[`PBT_C_MSI]))
      else $error("legacy pin not one-hot");
   chk_cto_cause: assert property (cto_pulse |-> $past(np_busy_ff) && !np_busy_ff)
      else $error("timeout without outstanding request");
   chk_msi_range: assert property (msi_req |-> {1'b0, msi_vec} < mvecs &&
                                   $past(ctrl_ff[`PBT_C_MSI]))
      else $error("vector outside granted range");

   cov_forward: cover property (in_valid && hit_any && !tbl_hit ##1 out_valid);
   cov_miss: cover property (in_valid && in_mem && !hit_any ##1 ur_valid);
   cov_table_read: cover property (in_valid && tbl_hit && !in_wr ##1 tbl_rvalid);
   cov_timeout: cover property (cto_pulse);
endmodule
`default_nettype wire

// [src/pbt_defines.svh]
// Register offsets, field positions, reset values and timing figures of the BAR decoder
`ifndef PBT_DEFINES_SVH
`define PBT_DEFINES_SVH
// Register byte offsets, then the BAR page and BAR sub-register indices
`define PBT_REG_CTRL 12'h000
`define PBT_REG_BAREN 12'h004
`define PBT_REG_STATUS 12'h008
`define PBT_REG_INTR 12'h00c
`define PBT_BAR_PAGE 4'h1
`define PBT_BAR_SIZE 3'h0
`define PBT_BAR_BLO 3'h1
`define PBT_BAR_BHI 3'h2
`define PBT_BAR_XLO 3'h3
`define PBT_BAR_XHI 3'h4
// CTRL fields
`define PBT_C_RP 0
`define PBT_C_MSIX 1
`define PBT_C_VTON 2
`define PBT_C_VTBAR 5:3
`define PBT_C_CTOS 6
`define PBT_C_MSI 7
`define PBT_C_XCFG 8
`define PBT_CTRL_RST 9'h086
// BAREN fields: enables, then 64-bit flags of BARs 0, 2, 4
`define PBT_BAREN_RST 9'h001
// INTR fields, then the STATUS timeout bit
`define PBT_I_UCNT 3:0
`define PBT_I_MVEC 6:4
`define PBT_I_LEG 9:8
`define PBT_INTR_RST 10'h000
`define PBT_ST_CTO 12
// Window sizes and table region as log2 bytes, then the message vector limit as log2
`define PBT_SZ_MIN 6'h0c
`define PBT_SZ_MAX32 6'h1f
`define PBT_SZ_MAX64 6'h26
`define PBT_SZ_RST 6'h0c
`define PBT_VT_LOG2 6'h10
`define PBT_MVEC_MAX 3'h4
// Completion timeout
`define PBT_CLK_MHZ 200
`define PBT_CTO_LONG_MS 50
`define PBT_CTO_SHORT_US 50
`define PBT_CTO_W 24
`endif

// [src/pbt_pkg.sv]
// Types shared by the BAR decoder files
package pbt_pkg;
   typedef logic [63:0] pbt_addr_t;
   typedef enum logic [1:0] {
      PBT_OKAY = 2'b00,
      PBT_SLVERR = 2'b10
   } pbt_resp_t;
   typedef enum logic [1:0] {
      PBT_INTA = 2'b00,
      PBT_INTB = 2'b01,
      PBT_INTC = 2'b10,
      PBT_INTD = 2'b11
   } pbt_intx_t;
endpackage

// [src/pbt_vt_mem.sv]
// Vector table storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module pbt_vt_mem #(
   parameter int WORDS = 64,
   parameter int AW = 6
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [AW-1:0] addr,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata
);
   logic [31:0] mem [WORDS];

   // Storage has no reset; software programs every entry it uses
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[addr] <= wdata;
      end
   end

   // Read data always come from this flip-flop
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 32'h0;
      end else begin
         rdata <= mem[addr];
      end
   end
endmodule
`default_nettype wire

// [test/pbt_link_model.sv]
// Link-side requester standing in for the far end of the link
`timescale 1ns/10ps
`default_nettype none
module pbt_link_model (
   input wire logic clk,
   output logic in_valid,
   output pbt_pkg::pbt_addr_t in_addr,
   output logic in_mem,
   output logic in_wr,
   output logic in_np,
   output logic [31:0] in_wdata,
   output logic cpl_done
);
   import pbt_pkg::*;
   initial begin
      {in_valid, in_mem, in_wr, in_np, cpl_done} = '0;
      in_addr = '0;
      in_wdata = '0;
   end
   // One request per call; the released address is inverted so stale bits never hit
   task send(input pbt_addr_t a, input logic m, input logic np);
      in_addr <= a;
      in_mem <= m;
      in_wr <= !np;
      in_np <= np;
      in_wdata <= a[31:0];
      in_valid <= 1'h1;
      @(posedge clk);
      in_valid <= 1'h0;
      in_addr <= ~a;
   endtask
   // Completion for the outstanding non-posted request
   task done;
      cpl_done <= 1'h1;
      @(posedge clk);
      cpl_done <= 1'h0;
   endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the BAR decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import pbt_pkg::*;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, in_wdata, out_wdata, tbl_rdata, d;
   logic [3:0] s_axi_wstrb, intx, msi_vec;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic in_valid, in_mem, in_wr, in_np, cpl_done, out_valid, out_wr, out_np;
   logic ur_valid, tbl_rvalid, cto_pulse, msi_req, msix_ext, ext_cfg_en;
   logic [2:0] out_bar;
   logic [15:0] usr_irq;
   pbt_resp_t s_axi_bresp, s_axi_rresp, r;
   pbt_addr_t in_addr, out_addr;
   int n_errors = 0;
   int comparisons = 0;
   int n;
   // Timeout counts cut down so the run stays short
   pbt_bar_decode #(.CTO_LONG_CYC(50), .CTO_SHORT_CYC(20)) dut (.*);
   pbt_link_model lk (.*);
   always #2.5 clk = ~clk;
   task chk(input logic [63:0] g, input logic [63:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task complete_run;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // A wait that ran out of cycles ends the run
   task hung;
      n_errors++;
      complete_run();
   endtask
   // Outputs are sampled mid-cycle, where they are settled, and acted on at the edge
   // Ready stays high after the answer, so back-to-back calls never drive it twice at once
   task wr(input logic [11:0] a, input logic [31:0] v);
      logic ah, wh, bh;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      bh = 1'h0;
      for (n = 0; n < 50 && !bh; n++) begin
         @(negedge clk);
         ah = s_axi_awvalid && s_axi_awready;
         wh = s_axi_wvalid && s_axi_wready;
         bh = s_axi_bvalid;
         @(posedge clk);
         if (ah) s_axi_awvalid <= 1'h0;
         if (wh) s_axi_wvalid <= 1'h0;
      end
      if (!bh) hung();
   endtask
   task rd(input logic [11:0] a);
      logic ah, rh;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      rh = 1'h0;
      for (n = 0; n < 50 && !rh; n++) begin
         @(negedge clk);
         ah = s_axi_arvalid && s_axi_arready;
         rh = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
         if (ah) s_axi_arvalid <= 1'h0;
      end
      if (!rh) hung();
   endtask
   task rc(input logic [11:0] a, input logic [31:0] e, input pbt_resp_t er = PBT_OKAY);
      rd(a);
      chk(d, e);
      chk(r, er);
   endtask
   // Verdict one cycle on: 1 forward, 2 unsupported, 3 table read, 0 nothing
   // x is the translated address for a forward and the table word for a table read
   task inb(input pbt_addr_t a, input logic m, input logic np, input int k, input pbt_addr_t x);
      lk.send(a, m, np);
      @(negedge clk);
      chk({out_valid, ur_valid, tbl_rvalid}, {k == 1, k == 2, k == 3});
      if (k == 1) chk(out_addr, x);
      if (k == 1) chk(out_bar, 3'h0);
      if (k == 1) chk({out_wr, out_np, out_wdata}, {!np, np, a[31:0]});
      if (k == 3) chk(tbl_rdata, x);
      @(posedge clk);
   endtask
   // Raise one user input and expect a message or a legacy pin within a few cycles
   task irq(input int i, input logic [3:0] v, input logic msi);
      usr_irq <= 16'h1 << i;
      for (n = 0; n < 8 && !(msi ? msi_req : |intx); n++) @(negedge clk);
      chk(n < 8, 1'h1);
      chk(msi ? msi_vec : intx, v);
      @(posedge clk);
      usr_irq <= 16'h0;
      repeat (4) @(posedge clk);
   endtask
   // Counts cycles from a non-posted forward to the timeout pulse
   task cto(input logic c, input int lo, input int hi);
      lk.send(64'h10000, 1'h1, 1'h1);
      if (c) lk.done();
      for (n = 0; n < 80 && !cto_pulse; n++) @(negedge clk);
      chk(n >= lo && n <= hi, 1'h1);
      @(posedge clk);
   endtask
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = 12'h0;
      s_axi_araddr = 12'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      usr_irq = 16'h0;
      repeat (8) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      rc(12'h000, 32'h086);
      rc(12'h004, 32'h001);
      rc(12'h100, 32'h04c);
      rc(12'h0f0, 32'h0, PBT_SLVERR);
      wr(12'h100, 32'h3f);
      rc(12'h100, 32'h05f);
      wr(12'h100, 32'h05);
      rc(12'h100, 32'h04c);
      // BAR0 at 64K, translated to 512M; table off so the whole window forwards
      wr(12'h000, 32'h080);
      wr(12'h104, 32'h10000);
      wr(12'h10c, 32'h20000000);
      inb(64'h10010, 1'h1, 1'h0, 1, 64'h20000010);
      inb(64'h10ffc, 1'h1, 1'h0, 1, 64'h20000ffc);
      inb(64'h11000, 1'h1, 1'h0, 2, 64'h0);
      inb(64'hfffc, 1'h1, 1'h0, 2, 64'h0);
      inb(64'h10010, 1'h0, 1'h0, 0, 64'h0);
      wr(12'h000, 32'h182);
      @(negedge clk);
      chk({msix_ext, ext_cfg_en}, 2'h3);
      @(posedge clk);
      inb(64'h10020, 1'h1, 1'h0, 1, 64'h20000020);
      wr(12'h000, 32'h086);
      inb(64'h10020, 1'h1, 1'h0, 0, 64'h0);
      inb(64'h10020, 1'h1, 1'h1, 3, 64'h10020);
      // Short, long, then long cancelled by a completion
      wr(12'h000, 32'h0c0);
      cto(1'h0, 18, 22);
      wr(12'h000, 32'h080);
      cto(1'h0, 48, 52);
      cto(1'h1, 80, 80);
      // Timeout flag is sticky until written with one; nothing is outstanding now
      rd(12'h008);
      chk(d[13:12], 2'h1);
      wr(12'h008, 32'h1000);
      rd(12'h008);
      chk(d[12], 1'h0);
      wr(12'h00c, 32'h013);
      irq(3, 4'h1, 1'h1);
      wr(12'h00c, 32'h000);
      irq(0, 4'h0, 1'h1);
      wr(12'h000, 32'h000);
      for (int p = 0; p < 4; p++) begin
         wr(12'h00c, p << 8);
         irq(0, 4'h1 << p, 1'h0);
      end
      // 64-bit BAR0 swallows BAR1 and reads prefetchable
      wr(12'h004, 32'h043);
      rd(12'h008);
      chk(d[11:0], 12'h041);
      rc(12'h100, 32'h1cc);
      wr(12'h100, 32'h3f);
      rc(12'h100, 32'h1e6);
      wr(12'h004, 32'h03f);
      rd(12'h008);
      chk(d[5:0], 6'h3f);
      wr(12'h000, 32'h081);
      rd(12'h008);
      chk(d[5:0], 6'h03);
      complete_run();
   end
endmodule
`default_nettype wire
